// [verilog/ccs_map.vh]
// Register map, field positions and reset values of the clocked serial channel.
// Assumes a 32-bit Avalon-MM slave: byte address = 4 * register index.
`ifndef CCS_MAP_VH
`define CCS_MAP_VH

// Register indices
`define CCS_IDX_FMT     24'hffff88
`define CCS_IDX_DIV     24'hffff89
`define CCS_IDX_CTL     24'hffff8a
`define CCS_IDX_TDR     24'hffff8b
`define CCS_IDX_STS     24'hffff8c
`define CCS_IDX_RDR     24'hffff8d

// Format register fields
`define CCS_FMT_SYNC    7
`define CCS_FMT_PSH     1
`define CCS_FMT_PSL     0

// Control register fields
`define CCS_CTL_TE      5
`define CCS_CTL_RE      4
`define CCS_CTL_CKSH    1
`define CCS_CTL_CKSL    0

// Status register fields
`define CCS_STS_TRANSMIT_BUFFER_EMPTY_FLAG    7
`define CCS_STS_RECEIVE_FULL_FLAG    6
`define CCS_STS_OVERRUN_ERROR_FLAG    5
`define CCS_STS_FER     4
`define CCS_STS_PER     3
`define CCS_STS_TRANSMIT_END_FLAG    2

// Reset values
`define CCS_RST_FMT     8'h00
`define CCS_RST_DIV     8'hff
`define CCS_RST_CTL     8'h00
`define CCS_RST_TDR     8'hff
`define CCS_RST_RDR     8'h00
`define CCS_RST_TRANSMIT_BUFFER_EMPTY_FLAG    1'b1
`define CCS_RST_TRANSMIT_END_FLAG    1'b1

// Last bit index of an eight-bit frame
`define CCS_LAST_BIT    3'h7

`endif

// [verilog/ccs_baud_gen.v]
// Baud rate generator of one serial channel: half-bit enable pulses.
// Assumes one clock; run low holds the counters cleared so each start
// is followed by a full half period.
`timescale 1ns/1ps
`default_nettype none

module ccs_baud_gen (
   input  wire       clock_in,
   input  wire       resetn_in,
   input  wire       run_in,
   input  wire [1:0] prescale_in,
   input  wire [7:0] divisor_in,
   output reg        tick_out
);

   reg  [6:0] pre_q;
   reg  [7:0] div_q;
   wire [6:0] pre_lim;

   // Half bit = 2 * 4^n * (N + 1) clocks, so a full bit is 4 * 4^n * (N + 1)
   assign pre_lim = (prescale_in == 2'h0) ? 7'h01 :
                    (prescale_in == 2'h1) ? 7'h07 :
                    (prescale_in == 2'h2) ? 7'h1f : 7'h7f;

   always @(posedge clock_in or negedge resetn_in) begin
      if (!resetn_in) begin
         pre_q    <= 7'h00;
         div_q    <= 8'h00;
         tick_out <= 1'b0;
      end else if (!run_in) begin
         pre_q    <= 7'h00;
         div_q    <= 8'h00;
         tick_out <= 1'b0;
      end else begin
         tick_out <= 1'b0;
         if (pre_q >= pre_lim) begin
            pre_q <= 7'h00;
            if (div_q >= divisor_in) begin
               div_q    <= 8'h00;
               tick_out <= 1'b1;
            end else begin
               div_q <= div_q + 8'h01;
            end
         end else begin
            pre_q <= pre_q + 7'h01;
         end
      end
   end

endmodule

`default_nettype wire

// [verilog/ccs_channel.v]
// Clocked synchronous serial channel with double-buffered transmit and
// receive paths, own baud rate generator and Avalon-MM register slave.
// Assumes pins are synchronous to clock_in; the serial clock pin is
// three signals, the board resolves the wire.
//
// The Avalon-MM interface to the registers was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "ccs_map.vh"

module ccs_channel (
   input  wire        clock_in,
   input  wire        resetn_in,
   // Avalon-MM slave
   input  wire [25:0] avs_address_in,
   input  wire        avs_read_in,
   input  wire        avs_write_in,
   input  wire [3:0]  avs_byteenable_in,
   input  wire [31:0] avs_writedata_in,
   output reg  [31:0] avs_readdata_out,
   output reg         avs_waitrequest_out,
   // Serial pins
   input  wire        rxd_in,
   output reg         txd_out,
   input  wire        sck_in,
   output reg         sck_out,
   output reg         sck_oe_out
);

   // Word-address match against a register index
   function hit;
      input [25:0] addr;
      input [23:0] idx;
      begin
         hit = (addr[25:2] == idx);
      end
   endfunction

   // Register file
   reg  [7:0] fmt_q;
   reg  [7:0] div_q;
   reg  [7:0] ctl_q;
   reg  [7:0] tdr_q;
   reg  [7:0] rdr_q;
   reg        transmit_buffer_empty_flag_q;
   reg        receive_full_flag_q;
   reg        overrun_error_flag_q;
   reg        fer_q;
   reg        per_q;
   reg        transmit_end_flag_q;
   reg        transmit_buffer_empty_flag_d;
   reg        receive_full_flag_d;
   reg        overrun_error_flag_d;
   reg        fer_d;
   reg        per_d;
   reg        transmit_end_flag_d;

   // Shifters and serial clock state
   reg  [7:0] tsr_q;
   reg  [2:0] tx_cnt_q;
   reg        tx_busy_q;
   reg  [7:0] rsr_q;
   reg  [2:0] rx_cnt_q;
   reg        sck_prev_q;

   // Bus handshake
   wire       req;
   wire       acc;
   wire       wr_en;
   reg  [7:0] rd_byte;

   // Mode decode
   wire       sync_mode;
   wire       ext_clk;
   wire       tx_en;
   wire       rx_en;
   wire       run_int;
   wire       tick;
   wire       fall_ev;
   wire       rise_ev;
   wire       last_rise;
   wire       tx_start;
   wire       tx_reload;
   wire       tx_stop;
   wire       rx_done;
   wire       sts_wr;

   assign sync_mode = fmt_q[`CCS_FMT_SYNC];
   assign ext_clk   = ctl_q[`CCS_CTL_CKSH];
   assign tx_en     = ctl_q[`CCS_CTL_TE] & sync_mode;
   assign rx_en     = ctl_q[`CCS_CTL_RE] & sync_mode;

   // Receive-only with internal clock keeps the serial clock running,
   // otherwise the clock only runs while a frame is being shifted
   assign run_int = sync_mode & ~ext_clk &
                    (tx_busy_q | (rx_en & ~ctl_q[`CCS_CTL_TE]));

   ccs_baud_gen u_baud (
      .clock_in    (clock_in),
      .resetn_in   (resetn_in),
      .run_in      (run_int),
      .prescale_in (fmt_q[`CCS_FMT_PSH:`CCS_FMT_PSL]),
      .divisor_in  (div_q),
      .tick_out    (tick)
   );

   // Serial clock edges, internal or taken from the pin
   assign fall_ev = ext_clk ? (sck_prev_q & ~sck_in)
                            : (tick & sck_out);
   assign rise_ev = ext_clk ? (~sck_prev_q & sck_in)
                            : (tick & ~sck_out);

   // Transmit sequencing
   assign last_rise = tx_busy_q & rise_ev & (tx_cnt_q == `CCS_LAST_BIT);
   assign tx_start  = ~tx_busy_q & tx_en & ~transmit_buffer_empty_flag_q;
   assign tx_reload = last_rise & tx_en & ~transmit_buffer_empty_flag_q;
   assign tx_stop   = last_rise & ~(tx_en & ~transmit_buffer_empty_flag_q);

   // Receive frame complete on the eighth rising edge
   assign rx_done = rx_en & rise_ev & (rx_cnt_q == `CCS_LAST_BIT);

   // Bus access: one wait cycle, then the request completes
   assign req    = avs_read_in | avs_write_in;
   assign acc    = req & ~avs_waitrequest_out;
   assign wr_en  = avs_write_in & acc & avs_byteenable_in[0];
   assign sts_wr = wr_en & hit(avs_address_in, `CCS_IDX_STS);

   always @(posedge clock_in or negedge resetn_in) begin
      if (!resetn_in) begin
         avs_waitrequest_out <= 1'b1;
      end else begin
         avs_waitrequest_out <= ~(req & avs_waitrequest_out);
      end
   end

   // Read mux; shifters have no address at all
   always @* begin
      rd_byte = 8'h00;
      if (hit(avs_address_in, `CCS_IDX_FMT)) begin
         rd_byte = fmt_q;
      end else if (hit(avs_address_in, `CCS_IDX_DIV)) begin
         rd_byte = div_q;
      end else if (hit(avs_address_in, `CCS_IDX_CTL)) begin
         rd_byte = ctl_q;
      end else if (hit(avs_address_in, `CCS_IDX_TDR)) begin
         rd_byte = tdr_q;
      end else if (hit(avs_address_in, `CCS_IDX_STS)) begin
         rd_byte = {transmit_buffer_empty_flag_q, receive_full_flag_q, overrun_error_flag_q, fer_q, per_q, transmit_end_flag_q, 2'h0};
      end else if (hit(avs_address_in, `CCS_IDX_RDR)) begin
         rd_byte = rdr_q;
      end
   end

   // Read data is captured in the wait cycle and stands at the accepting edge
   always @(posedge clock_in or negedge resetn_in) begin
      if (!resetn_in) begin
         avs_readdata_out <= 32'h0000_0000;
      end else if (avs_read_in & avs_waitrequest_out) begin
         avs_readdata_out <= {24'h00_0000, rd_byte};
      end
   end

   // Software-written registers
   always @(posedge clock_in or negedge resetn_in) begin
      if (!resetn_in) begin
         fmt_q <= `CCS_RST_FMT;
         div_q <= `CCS_RST_DIV;
         ctl_q <= `CCS_RST_CTL;
         tdr_q <= `CCS_RST_TDR;
      end else if (wr_en) begin
         if (hit(avs_address_in, `CCS_IDX_FMT)) begin
            fmt_q <= avs_writedata_in[7:0];
         end else if (hit(avs_address_in, `CCS_IDX_DIV)) begin
            div_q <= avs_writedata_in[7:0];
         end else if (hit(avs_address_in, `CCS_IDX_CTL)) begin
            ctl_q <= avs_writedata_in[7:0];
         end else if (hit(avs_address_in, `CCS_IDX_TDR)) begin
            tdr_q <= avs_writedata_in[7:0];
         end
      end
   end

   // Status flags: hardware set wins over a software clear in the same
   // cycle, and a written 1 leaves a flag as it is
   always @* begin
      transmit_buffer_empty_flag_d = transmit_buffer_empty_flag_q;
      if (sts_wr & ~avs_writedata_in[`CCS_STS_TRANSMIT_BUFFER_EMPTY_FLAG]) begin
         transmit_buffer_empty_flag_d = 1'b0;
      end
      if (tx_start | tx_reload) begin
         transmit_buffer_empty_flag_d = 1'b1;
      end
   end

   always @* begin
      receive_full_flag_d = receive_full_flag_q;
      overrun_error_flag_d = overrun_error_flag_q;
      fer_d  = fer_q;
      per_d  = per_q;
      if (sts_wr) begin
         receive_full_flag_d = receive_full_flag_q & avs_writedata_in[`CCS_STS_RECEIVE_FULL_FLAG];
         overrun_error_flag_d = overrun_error_flag_q & avs_writedata_in[`CCS_STS_OVERRUN_ERROR_FLAG];
         fer_d  = fer_q  & avs_writedata_in[`CCS_STS_FER];
         per_d  = per_q  & avs_writedata_in[`CCS_STS_PER];
      end
      if (rx_done & ~receive_full_flag_q) begin
         receive_full_flag_d = 1'b1;
      end
      if (rx_done & receive_full_flag_q) begin
         overrun_error_flag_d = 1'b1;
      end
   end

   // End flag is read-only: hardware alone moves it
   always @* begin
      transmit_end_flag_d = transmit_end_flag_q;
      if (tx_start) begin
         transmit_end_flag_d = 1'b0;
      end
      if (tx_stop) begin
         transmit_end_flag_d = 1'b1;
      end
   end

   always @(posedge clock_in or negedge resetn_in) begin
      if (!resetn_in) begin
         transmit_buffer_empty_flag_q <= `CCS_RST_TRANSMIT_BUFFER_EMPTY_FLAG;
         receive_full_flag_q <= 1'b0;
         overrun_error_flag_q <= 1'b0;
         fer_q  <= 1'b0;
         per_q  <= 1'b0;
         transmit_end_flag_q <= `CCS_RST_TRANSMIT_END_FLAG;
      end else begin
         transmit_buffer_empty_flag_q <= transmit_buffer_empty_flag_d;
         receive_full_flag_q <= receive_full_flag_d;
         overrun_error_flag_q <= overrun_error_flag_d;
         fer_q  <= fer_d;
         per_q  <= per_d;
         transmit_end_flag_q <= transmit_end_flag_d;
      end
   end

   // Internal serial clock: idles high, toggles on each half-bit tick
   always @(posedge clock_in or negedge resetn_in) begin
      if (!resetn_in) begin
         sck_out    <= 1'b1;
         sck_oe_out <= 1'b0;
         sck_prev_q <= 1'b1;
      end else begin
         sck_prev_q <= sck_in;
         sck_oe_out <= sync_mode & ~ext_clk;
         if (!run_int) begin
            sck_out <= 1'b1;
         end else if (tick) begin
            sck_out <= ~sck_out;
         end
      end
   end

   // Transmit shifter
   always @(posedge clock_in or negedge resetn_in) begin
      if (!resetn_in) begin
         tsr_q     <= 8'h00;
         tx_cnt_q  <= 3'h0;
         tx_busy_q <= 1'b0;
         txd_out   <= 1'b1;
      end else if (tx_start) begin
         tsr_q     <= tdr_q;
         tx_cnt_q  <= 3'h0;
         tx_busy_q <= 1'b1;
      end else if (tx_busy_q) begin
         if (fall_ev) begin
            txd_out <= tsr_q[0];
         end
         if (tx_reload) begin
            tsr_q    <= tdr_q;
            tx_cnt_q <= 3'h0;
         end else if (tx_stop) begin
            // Pin keeps the last bit's level until a new frame starts or transmit is disabled, which drives it high
            tx_busy_q <= 1'b0;
         end else if (rise_ev) begin
            tsr_q    <= {1'b0, tsr_q[7:1]};
            tx_cnt_q <= tx_cnt_q + 3'h1;
         end
      end else if (!tx_en) begin
         txd_out <= 1'b1;
      end
   end

   // Receive shifter; a frame that finds the holding register still full
   // is dropped and flagged as overrun rather than overwriting unread data
   always @(posedge clock_in or negedge resetn_in) begin
      if (!resetn_in) begin
         rsr_q    <= 8'h00;
         rx_cnt_q <= 3'h0;
         rdr_q    <= `CCS_RST_RDR;
      end else if (!rx_en) begin
         rx_cnt_q <= 3'h0;
      end else if (rise_ev) begin
         rsr_q    <= {rxd_in, rsr_q[7:1]};
         rx_cnt_q <= rx_cnt_q + 3'h1;
         if (rx_done & ~receive_full_flag_q) begin
            rdr_q <= {rxd_in, rsr_q[7:1]};
         end
      end
   end

endmodule

`default_nettype wire

// [testbench/ccs_channel_sva.sv]
// Port checker for ccs_channel.
// Assumes the 32-bit register map of ccs_map.vh.
`timescale 1ns/1ps
`default_nettype none
`include "ccs_map.vh"
module ccs_channel_sva (
   input wire logic        clock_in,
   input wire logic        resetn_in,
   input wire logic [25:0] avs_address_in,
   input wire logic        avs_read_in,
   input wire logic        avs_write_in,
   input wire logic [31:0] avs_readdata_out,
   input wire logic        avs_waitrequest_out,
   input wire logic        txd_out,
   input wire logic        sck_out
);
   default clocking @(posedge clock_in); endclocking
   default disable iff (!resetn_in);
   wire        rd_done = avs_read_in && !avs_waitrequest_out;
   wire [23:0] idx     = avs_address_in[25:2];
   sequence s_req;
      $rose(avs_read_in || avs_write_in);
   endsequence
   sequence s_ack;
      !avs_waitrequest_out ##1 avs_waitrequest_out;
   endsequence
   AST_ONE_WAIT:
      assert property (s_req |=> s_ack) else $error("access not answered after one wait");
   AST_IDLE_WAIT:
      assert property (!(avs_read_in || avs_write_in) && !$past(avs_read_in || avs_write_in)
         |-> avs_waitrequest_out) else $error("waitrequest low without request");
   AST_RD_BYTE:
      assert property (rd_done |-> avs_readdata_out[31:8] == 24'h0)
         else $error("read data upper bits set");
   AST_UNMAPPED:
      assert property (rd_done && (idx < `CCS_IDX_FMT || idx > 24'hffff8d)
         |-> avs_readdata_out == 32'h0) else $error("unmapped read not zero");
   AST_STS_LOW:
      assert property (rd_done && idx == `CCS_IDX_STS |-> avs_readdata_out[1:0] == 2'b00)
         else $error("status low bits set");
   AST_RD_HOLD:
      assert property (!$past(avs_read_in) |-> $stable(avs_readdata_out))
         else $error("read data moved without read");
   AST_TXD_EDGE:
      assert property ($rose(sck_out) || (!sck_out && !$fell(sck_out)) |-> $stable(txd_out))
         else $error("transmit data moved off the falling clock");
   AST_SCK_HALF:
      assert property ($changed(sck_out) |=> $stable(sck_out))
         else $error("serial clock phase shorter than two cycles");
endmodule
`default_nettype wire

// [testbench/ccs_peer_model.sv]
// Peer serial controller: samples transmit data on serial clock rises
// and shifts receive data out on falls. Assumes a pulled-up clock wire.
`timescale 1ns/1ps
`default_nettype none
module ccs_peer_model (
   input  wire logic        clock_in,
   input  wire logic        sck_in,
   input  wire logic        txd_in,
   input  wire logic [7:0]  send_in,
   output var  logic        rxd_out,
   output var  logic [15:0] got_out,
   output var  logic [7:0]  per_max_out
);
   logic       sck_q = 1'b1;
   logic [2:0] nb    = 3'h0;
   logic [2:0] idx   = 3'h0;
   logic [7:0] sh    = 8'h0;
   logic [7:0] cnt   = 8'hff;
   initial begin
      rxd_out = 1'b1;
      got_out = 16'h0;
      per_max_out = 8'h0;
   end
   always @(posedge clock_in) begin
      sck_q <= sck_in;
      if (cnt != 8'hff) cnt <= cnt + 8'h1;
      if (sck_in && !sck_q) begin // LSB first, sampled on rise
         sh <= {txd_in, sh[7:1]};
         nb <= nb + 3'h1;
         cnt <= 8'h1;
         // Long idle spans are not bit periods, so they are left out
         if (cnt < 8'h40 && cnt > per_max_out) per_max_out <= cnt;
         if (nb == 3'h7) got_out <= {txd_in, sh[7:1], got_out[15:8]};
      end
      if (!sck_in && sck_q) begin // Data changes on fall
         rxd_out <= send_in[idx];
         idx <= idx + 3'h1;
      end
   end
endmodule
`default_nettype wire

// [testbench/ccs_channel_tb.sv]
// Self-checking bench for ccs_channel with a peer model on the pins.
// Assumes the register map of ccs_map.vh and one wait per access.
`timescale 1ns/1ps
`default_nettype none
`include "ccs_map.vh"
module ccs_channel_tb;
   localparam logic [23:0] IX_TXH = 24'hffff8b;
   localparam logic [23:0] IX_RXH = 24'hffff8d;
   logic        clock_in  = 1'b0;
   logic        resetn_in = 1'b0;
   logic [25:0] addr      = 26'h0;
   logic        rd        = 1'b0;
   logic        wr        = 1'b0;
   logic [3:0]  be        = 4'h1;
   logic [31:0] wdata     = 32'h0;
   logic [7:0]  send      = 8'h96;
   logic [31:0] q;
   wire  [31:0] rdata;
   wire  [15:0] got;
   wire  [7:0]  per_max;
   wire         waitreq, rxd, txd, sck, sck_oe;
   wire         sck_wire;
   int          err_count  = 0;
   int          n_compared = 0;
   // Released clock wire is pulled up
   assign sck_wire = sck_oe ? sck : 1'b1;
   always #12.5 clock_in = ~clock_in;
   ccs_channel u_ccs_channel (
      .clock_in(clock_in), .resetn_in(resetn_in), .avs_address_in(addr),
      .avs_read_in(rd), .avs_write_in(wr), .avs_byteenable_in(be),
      .avs_writedata_in(wdata), .avs_readdata_out(rdata), .avs_waitrequest_out(waitreq),
      .rxd_in(rxd), .txd_out(txd), .sck_in(sck_wire), .sck_out(sck), .sck_oe_out(sck_oe));
   ccs_peer_model u_ccs_peer_model (
      .clock_in(clock_in), .sck_in(sck_wire), .txd_in(txd), .send_in(send),
      .rxd_out(rxd), .got_out(got), .per_max_out(per_max));
   task automatic end_sim;
      $display("compared %0d mismatches %0d", n_compared, err_count);
      if (err_count == 0 && n_compared > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
      n_compared++;
      if (g !== e) begin
         err_count++;
         $display("unexpected %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic bus(input logic w, input logic [23:0] ix, input logic [7:0] d);
      int i;
      @(posedge clock_in);
      addr  <= {ix, 2'b00};
      rd    <= !w;
      wr    <= w;
      wdata <= {24'h0, d};
      i = 0;
      do begin
         @(posedge clock_in);
         i++;
      end while (waitreq !== 1'b0 && i < 20);
      q = rdata;
      rd <= 1'b0;
      wr <= 1'b0;
      if (i >= 20) begin
         err_count++;
         end_sim();
      end
   endtask
   task automatic rdc(input string nm, input logic [23:0] ix, input logic [7:0] e);
      bus(1'b0, ix, 8'h0);
      chk(nm, {8'h0, e}, q[15:0]);
   endtask
   // Polls one status bit; running out of tries ends the run
   task automatic poll(input int b, input logic v);
      int i;
      i = 0;
      do begin
         bus(1'b0, `CCS_IDX_STS, 8'h0);
         i++;
      end while (q[b] !== v && i < 300);
      chk("status bit", {15'h0, v}, {15'h0, q[b]});
      if (i >= 300) end_sim();
   endtask
   initial begin
      repeat (2) @(posedge clock_in);
      resetn_in <= 1'b1;
      rdc("fmt", `CCS_IDX_FMT, 8'h00);
      rdc("div", `CCS_IDX_DIV, 8'hff);
      rdc("ctl", `CCS_IDX_CTL, 8'h00);
      rdc("tx_hold", IX_TXH, 8'hff);
      rdc("sts", `CCS_IDX_STS, 8'h84);
      rdc("rx_hold", IX_RXH, 8'h00);
      rdc("unmapped", 24'hffff8e, 8'h00);
      chk("txd", 16'h1, {15'h0, txd});
      bus(1'b1, IX_RXH, 8'h5a);
      rdc("rx_hold", IX_RXH, 8'h00);
      bus(1'b1, `CCS_IDX_STS, 8'hff);
      rdc("sts", `CCS_IDX_STS, 8'h84);
      be <= 4'h0;
      bus(1'b1, `CCS_IDX_FMT, 8'h80);
      be <= 4'h1;
      rdc("fmt", `CCS_IDX_FMT, 8'h00);
      bus(1'b1, `CCS_IDX_FMT, 8'h83);
      rdc("fmt", `CCS_IDX_FMT, 8'h83);
      bus(1'b1, `CCS_IDX_FMT, 8'h80);
      bus(1'b1, `CCS_IDX_DIV, 8'h03);
      bus(1'b1, IX_TXH, 8'ha5);
      rdc("tx_hold", IX_TXH, 8'ha5);
      bus(1'b1, `CCS_IDX_STS, 8'h7f);
      // Transmit still disabled: the byte must wait
      repeat (100) @(posedge clock_in);
      rdc("sts", `CCS_IDX_STS, 8'h04);
      chk("sck", 16'h1, {15'h0, sck});
      bus(1'b1, `CCS_IDX_CTL, 8'h20);
      poll(7, 1'b1);
      chk("end", 16'h0, {15'h0, q[2]});
      chk("oe", 16'h1, {15'h0, sck_oe});
      bus(1'b1, IX_TXH, 8'h3c);
      bus(1'b1, `CCS_IDX_STS, 8'h7f);
      bus(1'b1, `CCS_IDX_DIV, 8'h03);
      rdc("div", `CCS_IDX_DIV, 8'h03);
      poll(2, 1'b1);
      chk("bytes", 16'h3ca5, got);
      // Bit period 4 * (divisor + 1) clocks, no longer across frames
      chk("bit period", 16'h0010, {8'h0, per_max});
      repeat (40) @(posedge clock_in);
      chk("txd", 16'h0, {15'h0, txd});
      chk("sck", 16'h1, {15'h0, sck});
      bus(1'b1, `CCS_IDX_CTL, 8'h10);
      poll(6, 1'b1);
      rdc("rx_hold", IX_RXH, 8'h96);
      bus(1'b1, `CCS_IDX_STS, 8'hbf);
      poll(6, 1'b1);
      rdc("rx_hold", IX_RXH, 8'h96);
      // External clock source releases the serial clock pin
      bus(1'b1, `CCS_IDX_CTL, 8'h12);
      repeat (2) @(posedge clock_in);
      chk("oe", 16'h0, {15'h0, sck_oe});
      end_sim();
   end
endmodule
bind ccs_channel ccs_channel_sva u_ccs_channel_sva (
   .clock_in(clock_in), .resetn_in(resetn_in), .avs_address_in(avs_address_in),
   .avs_read_in(avs_read_in), .avs_write_in(avs_write_in),
   .avs_readdata_out(avs_readdata_out), .avs_waitrequest_out(avs_waitrequest_out),
   .txd_out(txd_out), .sck_out(sck_out));
`default_nettype wire
